// file: src/dmove_consts.svh
// Constants for the data-move instruction executor: encodings, fields, resets
// Assumes a 14-bit instruction word as fetched by the surrounding core
`ifndef DMOVE_CONSTS_SVH
`define DMOVE_CONSTS_SVH

// --------------------------------------------------------------------------
// Opcode matching (mask, value)
// --------------------------------------------------------------------------
`define OPC_IDLE_MASK   14'h3fff
`define OPC_IDLE_VAL    14'h0000
`define OPC_BANK_MASK   14'h3fe0
`define OPC_BANK_VAL    14'h0020
`define OPC_PAGE_MASK   14'h3f80
`define OPC_PAGE_VAL    14'h3180
`define OPC_ACC_MASK    14'h3f00
`define OPC_ACC_VAL     14'h3000
`define OPC_STF_MASK    14'h3f80
`define OPC_STF_VAL     14'h0080
`define OPC_SIND_MASK   14'h3ff8
`define OPC_SIND_VAL    14'h0018
`define OPC_SREL_MASK   14'h3f80
`define OPC_SREL_VAL    14'h3f80
`define OPC_CFG_MASK    14'h3fff
`define OPC_CFG_VAL     14'h0062

// --------------------------------------------------------------------------
// Operand field positions
// --------------------------------------------------------------------------
`define F_BANK_HI       4
`define F_PAGE_HI       6
`define F_ACC_HI        7
`define F_FILE_HI       6
`define F_SIND_SEL      2
`define F_MODE_HI       1
`define F_SREL_SEL      6
`define F_OFS_HI        5
`define F_OFS_SIGN      5

// --------------------------------------------------------------------------
// Reset values and file register map
// --------------------------------------------------------------------------
`define RST_BANK        5'h00
`define RST_PAGE        7'h00
`define RST_ACC         8'h00
`define RST_CFG         8'hff
`define RST_PTR         16'h0000
`define PTR_ONE         16'h0001
`define ADDR_PORT0      7'h00
`define ADDR_PORT1      7'h01
`define ZERO_BYTE       8'h00
`define ZERO_FILE       7'h00
`define ZERO_ADDR       16'h0000

`endif

// file: src/dmove_pkg.sv
// Types shared by the data-move executor and its pointer unit
// Assumes dmove_consts.svh supplies the numeric constants
package dmove_pkg;
  typedef enum logic [1:0] {
    PRE_INC  = 2'b00,
    PRE_DEC  = 2'b01,
    POST_INC = 2'b10,
    POST_DEC = 2'b11
  } pointer_update_code_t;

  typedef enum logic [2:0] {
    OP_NONE  = 3'b000,
    OP_IDLE  = 3'b001,
    OP_BANK  = 3'b010,
    OP_PAGE  = 3'b011,
    OP_ACC   = 3'b100,
    OP_STF   = 3'b101,
    OP_SIND  = 3'b110,
    OP_CFG   = 3'b111
  } op_t;
endpackage

// file: src/ptr_if.sv
// Link between the executor and the pointer unit
// Assumes one clock domain shared by both ends
`timescale 1ns/1ps
interface ptr_if;
  logic                       req;
  logic                       sel;
  logic                       rel;
  dmove_pkg::pointer_update_code_t mode;
  logic [5:0]                 ofs;
  logic [15:0]                addr;
  logic [15:0]                ptr0;
  logic [15:0]                ptr1;
  modport exec (output req, sel, rel, mode, ofs, input addr, ptr0, ptr1);
  modport unit (input req, sel, rel, mode, ofs, output addr, ptr0, ptr1);
endinterface

// file: src/ptr_unit.sv
// Two 16-bit pointer registers with effective address and update logic
// Assumes requests arrive as one-cycle strobes from the executor
`timescale 1ns/1ps
`include "dmove_consts.svh"
module ptr_unit (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  ptr_if.unit      p
);
  import dmove_pkg::*;

  typedef struct packed {
    logic [15:0] ptr0;
    logic [15:0] ptr1;
  } ptr_state_t;

  ptr_state_t  st;
  ptr_state_t  next_st;
  logic [15:0] cur;
  logic [15:0] stepped;
  logic [15:0] ofs_ext;

  always_comb begin
    next_st = st;
    cur     = p.sel ? st.ptr1 : st.ptr0;
    ofs_ext = {{10{p.ofs[`F_OFS_SIGN]}}, p.ofs};
    // Modulo 2^16 arithmetic wraps at both ends
    stepped = p.mode[0] ? cur - `PTR_ONE : cur + `PTR_ONE; // RL9
    if (p.rel) begin
      p.addr = cur + ofs_ext; // RL6
    end else if (!p.mode[1]) begin
      p.addr = stepped; // RL6
    end else begin
      p.addr = cur;
    end
    if (p.req && !p.rel) begin
      // Relative form leaves the pointer alone
      if (p.sel) begin
        next_st.ptr1 = stepped; // RL7
      end else begin
        next_st.ptr0 = stepped; // RL7
      end
    end
  end

  assign p.ptr0 = st.ptr0;
  assign p.ptr1 = st.ptr1;

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      st <= '{ptr0: `RST_PTR, ptr1: `RST_PTR};
    end else begin
      st <= next_st;
    end
  end
endmodule

// file: src/dmove_exec.sv
// Executor for the literal-load, accumulator-store, idle and config-load group
// Assumes the core presents one fetched instruction word per valid cycle
//
// Function
// (RL1) Bank literal: 5-bit operand into bank select, flags untouched.
// (RL2) Page literal: 7-bit operand into program counter high latch, flags untouched.
// (RL3) Accumulator literal: 8-bit operand into accumulator, one cycle, no flags.
// (RL4) Store accumulator to 7-bit file address, one word, one cycle, no flags.
// (RL5) Indirect store picks one of two pointers; code selects pre/post inc/dec.
// (RL6) Pre modes step pointer before write; relative adds signed offset -32..31.
// (RL7) Pointer ends incremented, decremented, or unchanged for relative form.
// (RL8) Indirect port has no storage; accesses go to the pointed address.
// (RL9) Pointers are 16-bit and wrap modulo 2^16.
// (RL10) Pointer updates and indirect stores never change status flags.
// (RL11) Config load copies accumulator to prescaler config in one cycle.
// (RL12) Idle changes nothing but advances the program counter in one cycle.
`timescale 1ns/1ps
`include "dmove_consts.svh"
module dmove_exec (
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RSTN,
  // Instruction from fetch
  input  wire logic        INSTR_VALID,
  input  wire logic [13:0] INSTR,
  // Architectural registers
  output logic [4:0]       BANK_SELECT_REG,
  output logic [6:0]       PROGRAM_COUNTER_HIGH_LATCH,
  output logic [7:0]       ACCUMULATOR_REG,
  output logic [7:0]       PRESCALER_CONFIG_REG,
  output logic [15:0]      POINTER0,
  output logic [15:0]      POINTER1,
  // Data memory write port
  output logic             MEM_WE,
  output logic [15:0]      MEM_ADDR,
  output logic [7:0]       MEM_WDATA,
  // Status and sequencing
  output logic             FLAGS_WE,
  output logic             PC_ADVANCE,
  output logic             ILLEGAL
);
  import dmove_pkg::*;

  typedef struct packed {
    logic [4:0]  bank;
    logic [6:0]  page;
    logic [7:0]  acc;
    logic [7:0]  cfg;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        adv;
    logic        ill;
  } exec_state_t;

  exec_state_t st;
  exec_state_t next_st;
  op_t         op;
  logic        rel_form;
  logic [15:0] ind_addr;
  logic [6:0]  file_addr;

  ptr_if pif ();

  ptr_unit u_ptr (
    .CLK_SYS (CLK_SYS),
    .RSTN    (RSTN),
    .p       (pif)
  );

  // ------------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------------
  function automatic logic hit(input logic [13:0] w, input logic [13:0] m,
                               input logic [13:0] v);
    hit = (w & m) == v;
  endfunction

  always_comb begin
    rel_form = 1'b0;
    if (hit(INSTR, `OPC_IDLE_MASK, `OPC_IDLE_VAL)) begin
      op = OP_IDLE;
    end else if (hit(INSTR, `OPC_CFG_MASK, `OPC_CFG_VAL)) begin
      op = OP_CFG;
    end else if (hit(INSTR, `OPC_BANK_MASK, `OPC_BANK_VAL)) begin
      op = OP_BANK;
    end else if (hit(INSTR, `OPC_PAGE_MASK, `OPC_PAGE_VAL)) begin
      op = OP_PAGE;
    end else if (hit(INSTR, `OPC_ACC_MASK, `OPC_ACC_VAL)) begin
      op = OP_ACC;
    end else if (hit(INSTR, `OPC_STF_MASK, `OPC_STF_VAL)) begin
      op = OP_STF;
    end else if (hit(INSTR, `OPC_SIND_MASK, `OPC_SIND_VAL)) begin
      op = OP_SIND;
    end else if (hit(INSTR, `OPC_SREL_MASK, `OPC_SREL_VAL)) begin
      op       = OP_SIND;
      rel_form = 1'b1;
    end else begin
      op = OP_NONE;
    end
  end

  // ------------------------------------------------------------------------
  // Pointer unit request
  // ------------------------------------------------------------------------
  assign pif.req  = INSTR_VALID && op == OP_SIND; // RL5
  assign pif.rel  = rel_form;
  assign pif.sel  = rel_form ? INSTR[`F_SREL_SEL] : INSTR[`F_SIND_SEL]; // RL5
  assign pif.mode = pointer_update_code_t'(INSTR[`F_MODE_HI:0]); // RL5
  assign pif.ofs  = INSTR[`F_OFS_HI:0];
  assign ind_addr = pif.addr;
  assign file_addr = INSTR[`F_FILE_HI:0];

  // ------------------------------------------------------------------------
  // Execute
  // ------------------------------------------------------------------------
  always_comb begin
    next_st       = st;
    next_st.we    = 1'b0;
    next_st.adv   = 1'b0;
    next_st.ill   = 1'b0;
    if (INSTR_VALID) begin
      next_st.adv = op != OP_NONE; // RL12
      next_st.ill = op == OP_NONE;
      unique case (op)
        OP_IDLE: begin
          next_st.adv = 1'b1; // RL12
        end
        OP_BANK: begin
          next_st.bank = INSTR[`F_BANK_HI:0]; // RL1
        end
        OP_PAGE: begin
          next_st.page = INSTR[`F_PAGE_HI:0]; // RL2
        end
        OP_ACC: begin
          next_st.acc = INSTR[`F_ACC_HI:0]; // RL3
        end
        OP_STF: begin
          // The indirect ports hold nothing; writing them targets the pointed address
          if (file_addr == `ADDR_PORT0) begin
            next_st.addr = pif.ptr0; // RL8
          end else if (file_addr == `ADDR_PORT1) begin
            next_st.addr = pif.ptr1; // RL8
          end else begin
            next_st.addr = {9'h000, file_addr}; // RL4
          end
          next_st.we    = 1'b1; // RL4
          next_st.wdata = st.acc;
        end
        OP_SIND: begin
          next_st.addr  = ind_addr; // RL6
          next_st.we    = 1'b1;
          next_st.wdata = st.acc;
        end
        OP_CFG: begin
          next_st.cfg = st.acc; // RL11
        end
        OP_NONE: begin
          next_st.adv = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      st <= '{bank: `RST_BANK, page: `RST_PAGE, acc: `RST_ACC, cfg: `RST_CFG,
             we: 1'b0, addr: `ZERO_ADDR, wdata: `ZERO_BYTE, adv: 1'b0, ill: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------------
  assign BANK_SELECT_REG            = st.bank;
  assign PROGRAM_COUNTER_HIGH_LATCH = st.page;
  assign ACCUMULATOR_REG            = st.acc;
  assign PRESCALER_CONFIG_REG       = st.cfg;
  assign POINTER0                   = pif.ptr0;
  assign POINTER1                   = pif.ptr1;
  assign MEM_WE                     = st.we;
  assign MEM_ADDR                   = st.addr;
  assign MEM_WDATA                  = st.wdata;
  // No instruction of this group touches a status flag
  assign FLAGS_WE                   = 1'b0; // RL10
  assign PC_ADVANCE                 = st.adv;
  assign ILLEGAL                    = st.ill;
endmodule

// file: test/dmove_exec_asserts.sv
// Checker for the data-move executor
// Assumes it is bound onto dmove_exec; one clock domain
`timescale 1ns/1ps
`include "dmove_consts.svh"
module dmove_exec_asserts (
  // Clock, reset, instruction
  input wire logic        CLK_SYS,
  input wire logic        RSTN,
  input wire logic        INSTR_VALID,
  input wire logic [13:0] INSTR,
  // Watched outputs
  input wire logic [4:0]  BANK_SELECT_REG,
  input wire logic [6:0]  PROGRAM_COUNTER_HIGH_LATCH,
  input wire logic [7:0]  ACCUMULATOR_REG,
  input wire logic [7:0]  PRESCALER_CONFIG_REG,
  input wire logic [15:0] POINTER0,
  input wire logic [15:0] POINTER1,
  input wire logic        MEM_WE,
  input wire logic [15:0] MEM_ADDR,
  input wire logic [7:0]  MEM_WDATA,
  input wire logic        FLAGS_WE,
  input wire logic        PC_ADVANCE,
  input wire logic        ILLEGAL
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  // Reset is sampled in every opcode trigger: at the release edge the design still resets,
  // while the disable condition already sees reset high
  wire logic bank_op = RSTN && INSTR_VALID && ((INSTR & `OPC_BANK_MASK) == `OPC_BANK_VAL);
  wire logic page_op = RSTN && INSTR_VALID && ((INSTR & `OPC_PAGE_MASK) == `OPC_PAGE_VAL);
  wire logic acc_op  = RSTN && INSTR_VALID && ((INSTR & `OPC_ACC_MASK) == `OPC_ACC_VAL);
  wire logic stf_op  = RSTN && INSTR_VALID && ((INSTR & `OPC_STF_MASK) == `OPC_STF_VAL);
  wire logic sind_op = RSTN && INSTR_VALID && ((INSTR & `OPC_SIND_MASK) == `OPC_SIND_VAL);
  wire logic rel_op  = RSTN && INSTR_VALID && ((INSTR & `OPC_SREL_MASK) == `OPC_SREL_VAL);
  wire logic cfg_op  = RSTN && INSTR_VALID && (INSTR == `OPC_CFG_VAL);
  wire logic idle_op = RSTN && INSTR_VALID && (INSTR == `OPC_IDLE_VAL);
  wire logic none_op = RSTN && INSTR_VALID && !(bank_op || page_op || acc_op || stf_op
                       || sind_op || rel_op || cfg_op || idle_op);
  a_bank_load: assert property (bank_op |=> BANK_SELECT_REG == $past(INSTR[4:0]))
    else $error("bank literal not loaded");
  a_page_load: assert property (page_op |=> PROGRAM_COUNTER_HIGH_LATCH == $past(INSTR[6:0]))
    else $error("page literal not loaded");
  a_acc_load: assert property (acc_op |=> ACCUMULATOR_REG == $past(INSTR[7:0]) && PC_ADVANCE)
    else $error("acc literal not loaded");
  a_file_store: assert property (stf_op && INSTR[6:1] != 6'h00 |=> MEM_WE
    && MEM_ADDR == {9'h000, $past(INSTR[6:0])} && MEM_WDATA == $past(ACCUMULATOR_REG))
    else $error("file store wrong");
  a_port_redirect: assert property (stf_op && INSTR[6:1] == 6'h00 |=> MEM_WE
    && MEM_ADDR == $past(INSTR[0] ? POINTER1 : POINTER0) && $stable(POINTER0))
    else $error("port access not redirected");
  a_pre_inc: assert property (sind_op && INSTR[2:0] == 3'h0 |=> MEM_WE
    && POINTER0 == $past(POINTER0) + 16'h0001 && MEM_ADDR == POINTER0)
    else $error("pre-increment wrong");
  a_post_dec: assert property (sind_op && INSTR[2:0] == 3'h7 |=>
    POINTER1 == $past(POINTER1) - 16'h0001 && MEM_ADDR == $past(POINTER1))
    else $error("post-decrement wrong");
  a_rel_offset: assert property (rel_op |=> $stable(POINTER0) && $stable(POINTER1)
    && MEM_ADDR == $past((INSTR[6] ? POINTER1 : POINTER0) + {{10{INSTR[5]}}, INSTR[5:0]}))
    else $error("relative store wrong");
  a_cfg_load: assert property (cfg_op |=> PRESCALER_CONFIG_REG == $past(ACCUMULATOR_REG))
    else $error("config load wrong");
  a_flags_quiet: assert property (MEM_WE || PC_ADVANCE |-> !FLAGS_WE)
    else $error("status written");
  a_idle_quiet: assert property (idle_op |=> PC_ADVANCE && !MEM_WE
    && $stable(ACCUMULATOR_REG) && $stable(POINTER0))
    else $error("idle changed state");
  a_refused_word: assert property (none_op |=> ILLEGAL && !PC_ADVANCE && !MEM_WE
    && $stable(ACCUMULATOR_REG) && $stable(BANK_SELECT_REG))
    else $error("unknown word not refused");
endmodule
bind dmove_exec dmove_exec_asserts chk (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
  .INSTR_VALID(INSTR_VALID), .INSTR(INSTR), .BANK_SELECT_REG(BANK_SELECT_REG),
  .PROGRAM_COUNTER_HIGH_LATCH(PROGRAM_COUNTER_HIGH_LATCH),
  .ACCUMULATOR_REG(ACCUMULATOR_REG), .PRESCALER_CONFIG_REG(PRESCALER_CONFIG_REG),
  .POINTER0(POINTER0), .POINTER1(POINTER1), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR),
  .MEM_WDATA(MEM_WDATA), .FLAGS_WE(FLAGS_WE), .PC_ADVANCE(PC_ADVANCE), .ILLEGAL(ILLEGAL));

// file: test/testbench.sv
// Self-checking bench for the data-move executor
// Assumes dmove_exec and its checker are compiled first
`timescale 1ns/1ps
`include "dmove_consts.svh"
module testbench;
  logic        CLK_SYS = 1'b0;
  logic        RSTN = 1'b0;
  logic        INSTR_VALID = 1'b0;
  logic [13:0] INSTR = 14'h0000;
  logic [4:0]  q_bank, bank;
  logic [6:0]  q_page, page;
  logic [7:0]  q_acc, q_cfg, q_wd, acc, cfg, wd;
  logic [15:0] q_p0, q_p1, q_ad, p0, p1, ad;
  logic        q_we, q_fl, q_adv, q_ill, we, adv, ill;
  int          err_total = 0;
  int          n_checks = 0;
  int          cyc = 0;
  // Pointer wrap, both offset bounds and the redirected ports come first
  localparam logic [13:0] CORNER [16] = '{14'h30a5, 14'h0019, 14'h0018, 14'h001f,
    14'h001d, 14'h001a, 14'h001e, 14'h3fa0, 14'h3fdf, 14'h0080, 14'h0081, 14'h00ff,
    14'h0062, 14'h003f, 14'h31ff, 14'h2a55};
  always #20 CLK_SYS = ~CLK_SYS;
  dmove_exec dut (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR),
    .BANK_SELECT_REG(q_bank), .PROGRAM_COUNTER_HIGH_LATCH(q_page), .ACCUMULATOR_REG(q_acc),
    .PRESCALER_CONFIG_REG(q_cfg), .POINTER0(q_p0), .POINTER1(q_p1), .MEM_WE(q_we),
    .MEM_ADDR(q_ad), .MEM_WDATA(q_wd), .FLAGS_WE(q_fl), .PC_ADVANCE(q_adv), .ILLEGAL(q_ill));
  // ----
  // Reference model and checks
  // ----
  task automatic end_of_test;
    if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic model;
    logic [15:0] p;
    logic [13:0] w;
    w = INSTR;
    wd = acc;
    {we, adv, ill} = 3'b000;
    if (!RSTN) begin
      {bank, page, acc, cfg, p0, p1} = {5'h00, 7'h00, 8'h00, 8'hff, 32'h0000_0000};
    end else if (INSTR_VALID) begin
      adv = 1'b1;
      if (w == 14'h0000) begin
      end else if ((w & `OPC_BANK_MASK) == `OPC_BANK_VAL) bank = w[4:0];
      else if ((w & `OPC_PAGE_MASK) == `OPC_PAGE_VAL) page = w[6:0];
      else if ((w & `OPC_ACC_MASK) == `OPC_ACC_VAL) acc = w[7:0];
      else if (w == `OPC_CFG_VAL) cfg = acc;
      else if ((w & `OPC_STF_MASK) == `OPC_STF_VAL) begin
        we = 1'b1;
        ad = (w[6:1] == 6'h00) ? (w[0] ? p1 : p0) : {9'h000, w[6:0]};
      end else if ((w & `OPC_SIND_MASK) == `OPC_SIND_VAL) begin
        we = 1'b1;
        p = w[2] ? p1 : p0;
        if (!w[1]) p = w[0] ? p - 16'h0001 : p + 16'h0001;
        ad = p;
        if (w[1]) p = w[0] ? p - 16'h0001 : p + 16'h0001;
        if (w[2]) p1 = p;
        else p0 = p;
      end else if ((w & `OPC_SREL_MASK) == `OPC_SREL_VAL) begin
        we = 1'b1;
        ad = (w[6] ? p1 : p0) + {{10{w[5]}}, w[5:0]};
      end else begin
        adv = 1'b0;
        ill = 1'b1;
      end
    end
  endtask
  // Model sees the inputs of this edge before the new ones land
  task automatic step(input logic r, input logic v, input logic [13:0] w);
    @(posedge CLK_SYS);
    model();
    RSTN <= r;
    INSTR_VALID <= v;
    INSTR <= w;
    @(negedge CLK_SYS);
    chk(16'(q_bank), 16'(bank));
    chk(16'(q_page), 16'(page));
    chk(16'(q_acc), 16'(acc));
    chk(16'(q_cfg), 16'(cfg));
    chk(q_p0, p0);
    chk(q_p1, p1);
    chk(16'(q_we), 16'(we));
    if (we) chk(q_ad, ad);
    if (we) chk(16'(q_wd), 16'(wd));
    chk(16'(q_fl), 16'h0000);
    chk(16'(q_adv), 16'(adv));
    chk(16'(q_ill), 16'(ill));
  endtask
  function automatic logic [13:0] rnd;
    logic [13:0] k;
    k = 14'($urandom);
    case ($urandom % 9)
      0: return 14'h0000;
      1: return `OPC_BANK_VAL | (k & 14'h001f);
      2: return `OPC_PAGE_VAL | (k & 14'h007f);
      3: return `OPC_ACC_VAL | (k & 14'h00ff);
      4: return `OPC_STF_VAL | (k & 14'h007f);
      5: return `OPC_SIND_VAL | (k & 14'h0007);
      6: return `OPC_SREL_VAL | (k & 14'h007f);
      7: return `OPC_CFG_VAL;
      default: return 14'h2a55;
    endcase
  endfunction
  // ----
  // Sequence
  // ----
  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc > 8000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(98));
    repeat (10) step(1'b0, 1'b0, 14'h0000);
    foreach (CORNER[i]) step(1'b1, 1'b1, CORNER[i]);
    // Reset is pulled again every thousand cycles to test mid-run recovery
    for (int i = 0; i < 3000; i++) begin
      step(i % 1000 > 1, $urandom % 4 != 0, rnd());
    end
    step(1'b1, 1'b0, 14'h0000);
    end_of_test();
  end
endmodule
